// file: logic/epv_params.svh
// constants for the eprom programmer controller
`ifndef EPV_PARAMS_SVH
`define EPV_PARAMS_SVH
`define EPV_CLK_MHZ 25
`define EPV_PULSE_US 100
`define EPV_PULSE_CYC (`EPV_PULSE_US * `EPV_CLK_MHZ)
`define EPV_GAP_US 10
`define EPV_GAP_CYC (`EPV_GAP_US * `EPV_CLK_MHZ)
`define EPV_VPP_SETUP_US 10
`define EPV_VPP_SETUP_CYC (`EPV_VPP_SETUP_US * `EPV_CLK_MHZ)
`define EPV_VPP_HOLD_US 10
`define EPV_VPP_HOLD_CYC (`EPV_VPP_HOLD_US * `EPV_CLK_MHZ)
`define EPV_PULSE_COUNT 25
`define EPV_OSC_PERIODS 48
`define EPV_OSC_MIN_MHZ 4
`define EPV_SETTLE_CYC ((`EPV_OSC_PERIODS * `EPV_CLK_MHZ + \
    `EPV_OSC_MIN_MHZ - 1) / `EPV_OSC_MIN_MHZ)
`define EPV_OSC_DIV 5
`define EPV_SIG_MFR_ADDR 13'h0030
`define EPV_SIG_DEV_ADDR 13'h0031
`define EPV_ENC_LAST_ADDR 13'h001f
`endif

// file: logic/epv_pkg.sv
// types for the eprom programmer controller
`default_nettype none
package epv_pkg;
    typedef enum logic [2:0] {
        EPV_OP_CODE = 3'b000,
        EPV_OP_ENC = 3'b001,
        EPV_OP_LOCK1 = 3'b010,
        EPV_OP_LOCK2 = 3'b011,
        EPV_OP_VERIFY = 3'b100,
        EPV_OP_SIG = 3'b101
    } epv_op_t;
    typedef enum logic [3:0] {
        EPV_IDLE = 4'b0000,
        EPV_SETUP = 4'b0001,
        EPV_VPP_UP = 4'b0010,
        EPV_PULSE = 4'b0011,
        EPV_GAP = 4'b0100,
        EPV_VPP_DOWN = 4'b0101,
        EPV_HOLD = 4'b0110,
        EPV_RD_LOW = 4'b0111,
        EPV_RD_WAIT = 4'b1000,
        EPV_RD_FLOAT = 4'b1001
    } epv_state_t;
endpackage
`default_nettype wire

// file: logic/epv_osc_div.sv
// free running oscillator clock for the target
`timescale 1ns/1ps
`default_nettype none
`include "epv_params.svh"
module epv_osc_div #(
    parameter int DIV = `EPV_OSC_DIV
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    output var logic osc_out
);
    // full period count of DIV; 25 mhz / (2*...) is not exact, so rise at wrap and fall at DIV/2
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic osc_reg;
    logic osc_next;
    always_comb begin
        cnt_next = cnt_reg + 8'h01;
        osc_next = osc_reg;
        if (cnt_reg == 8'(DIV - 1)) begin
            cnt_next = 8'h00;
            osc_next = 1'b1;
        end else if (cnt_reg == 8'(DIV / 2 - 1)) begin
            osc_next = 1'b0;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
            osc_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            osc_reg <= osc_next;
        end
    end
    assign osc_out = osc_reg;
endmodule
`default_nettype wire

// file: logic/epv_programmer.sv
// host side controller that programs and verifies the on-chip eprom
`timescale 1ns/1ps
`default_nettype none
`include "epv_params.svh"
module epv_programmer
    import epv_pkg::*;
#(
    parameter int PULSE_CYC = `EPV_PULSE_CYC,
    parameter int PULSE_COUNT = `EPV_PULSE_COUNT,
    parameter int GAP_CYC = `EPV_GAP_CYC,
    parameter int SETTLE_CYC = `EPV_SETTLE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire epv_op_t cmd_op,
    input wire logic [12:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_match,
    output logic target_osc,
    output logic target_reset,
    output logic code_store_enable_pin,
    output logic program_strobe,
    output logic vpp_high_req,
    output logic external_access_vpp_pin,
    output logic [7:0] port1_out,
    output logic [4:0] port2_addr_out,
    output logic port2_bit7_enable,
    output logic port2_bit6_select,
    output logic port3_bit6_select,
    output logic port3_bit7_select,
    output logic [7:0] port0_out,
    output logic port0_oe,
    input wire logic [7:0] port0_in
);
    epv_state_t state_reg, state_next;
    epv_op_t op_reg, op_next;
    logic [12:0] addr_reg, addr_next;
    logic [7:0] data_reg, data_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [4:0] pulses_reg, pulses_next;
    logic verify_after_reg, verify_after_next;
    logic ready_reg, ready_next;
    logic rsp_valid_reg, rsp_valid_next;
    logic [7:0] rsp_data_reg, rsp_data_next;
    logic rsp_match_reg, rsp_match_next;
    logic strobe_reg, strobe_next;
    logic vpp_reg, vpp_next;
    logic rd_reg, rd_next;
    logic oe_reg, oe_next;
    logic osc_w;

    // target oscillator: 25 MHz / 5 = 5 MHz, inside 4..6 MHz
    epv_osc_div #(.DIV(`EPV_OSC_DIV)) u_osc (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .osc_out(osc_w)
    );

    function automatic logic is_prog(input epv_op_t op);
        is_prog = (op == EPV_OP_CODE) || (op == EPV_OP_ENC) ||
            (op == EPV_OP_LOCK1) || (op == EPV_OP_LOCK2);
    endfunction

    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        cnt_next = cnt_reg;
        pulses_next = pulses_reg;
        verify_after_next = verify_after_reg;
        ready_next = ready_reg;
        rsp_valid_next = 1'b0;
        rsp_data_next = rsp_data_reg;
        rsp_match_next = rsp_match_reg;
        strobe_next = strobe_reg;
        vpp_next = vpp_reg;
        rd_next = rd_reg;
        oe_next = oe_reg;
        if (cnt_reg != 16'h0000) begin
            cnt_next = cnt_reg - 16'h0001;
        end
        case (state_reg)
            EPV_IDLE: begin
                if (cmd_valid && ready_reg) begin
                    op_next = cmd_op;
                    addr_next = cmd_addr;
                    data_next = cmd_data;
                    ready_next = 1'b0;
                    verify_after_next = (cmd_op == EPV_OP_CODE);
                    // only code and encryption bytes drive port0
                    oe_next = (cmd_op == EPV_OP_CODE) ||
                        (cmd_op == EPV_OP_ENC);
                    cnt_next = 16'(SETTLE_CYC);
                    state_next = EPV_SETUP;
                end
            end
            EPV_SETUP: begin
                if (cnt_reg == 16'h0000) begin
                    if (is_prog(op_reg)) begin
                        vpp_next = 1'b1;
                        pulses_next = 5'(PULSE_COUNT);
                        cnt_next = 16'(`EPV_VPP_SETUP_CYC);
                        state_next = EPV_VPP_UP;
                    end else begin
                        rd_next = 1'b1;
                        cnt_next = 16'(SETTLE_CYC);
                        state_next = EPV_RD_WAIT;
                    end
                end
            end
            EPV_VPP_UP: begin
                if (cnt_reg == 16'h0000) begin
                    strobe_next = 1'b0;
                    cnt_next = 16'(PULSE_CYC);
                    state_next = EPV_PULSE;
                end
            end
            EPV_PULSE: begin
                if (cnt_reg == 16'h0000) begin
                    strobe_next = 1'b1;
                    pulses_next = pulses_reg - 5'h01;
                    if (pulses_reg == 5'h01) begin
                        cnt_next = 16'(`EPV_VPP_HOLD_CYC);
                        state_next = EPV_VPP_DOWN;
                    end else begin
                        cnt_next = 16'(GAP_CYC);
                        state_next = EPV_GAP;
                    end
                end
            end
            EPV_GAP: begin
                if (cnt_reg == 16'h0000) begin
                    strobe_next = 1'b0;
                    cnt_next = 16'(PULSE_CYC);
                    state_next = EPV_PULSE;
                end
            end
            EPV_VPP_DOWN: begin
                if (cnt_reg == 16'h0000) begin
                    vpp_next = 1'b0;
                    // hold covers both data hold and vpp settling
                    cnt_next = 16'(SETTLE_CYC);
                    state_next = EPV_HOLD;
                end
            end
            EPV_HOLD: begin
                if (cnt_reg == 16'h0000) begin
                    oe_next = 1'b0;
                    if (verify_after_reg) begin
                        verify_after_next = 1'b0;
                        op_next = EPV_OP_VERIFY;
                        cnt_next = 16'(SETTLE_CYC);
                        state_next = EPV_SETUP;
                    end else begin
                        rsp_valid_next = 1'b1;
                        rsp_match_next = 1'b1;
                        ready_next = 1'b1;
                        state_next = EPV_IDLE;
                    end
                end
            end
            EPV_RD_WAIT: begin
                if (cnt_reg == 16'h0000) begin
                    rsp_data_next = port0_in;
                    rsp_match_next = (port0_in == data_reg);
                    rd_next = 1'b0;
                    cnt_next = 16'(SETTLE_CYC);
                    state_next = EPV_RD_FLOAT;
                end
            end
            EPV_RD_FLOAT: begin
                if (cnt_reg == 16'h0000) begin
                    rsp_valid_next = 1'b1;
                    ready_next = 1'b1;
                    state_next = EPV_IDLE;
                end
            end
            default: begin
                state_next = EPV_IDLE;
                ready_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= EPV_IDLE;
            op_reg <= EPV_OP_VERIFY;
            addr_reg <= 13'h0000;
            data_reg <= 8'hff;
            cnt_reg <= 16'h0000;
            pulses_reg <= 5'h00;
            verify_after_reg <= 1'b0;
            ready_reg <= 1'b1;
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= 8'h00;
            rsp_match_reg <= 1'b0;
            strobe_reg <= 1'b1;
            vpp_reg <= 1'b0;
            rd_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            cnt_reg <= cnt_next;
            pulses_reg <= pulses_next;
            verify_after_reg <= verify_after_next;
            ready_reg <= ready_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_data_reg <= rsp_data_next;
            rsp_match_reg <= rsp_match_next;
            strobe_reg <= strobe_next;
            vpp_reg <= vpp_next;
            rd_reg <= rd_next;
            oe_reg <= oe_next;
        end
    end

    // mode pins are registered so every output comes from a flip-flop
    // built from next values so p2.7 moves on the same edge as oe, but after a code write it stays high until the verify read
    logic p27_reg, p27_next;
    logic p26_reg, p26_next;
    logic p36_reg, p36_next;
    logic p37_reg, p37_next;
    logic reset_reg;
    logic osc_pin_reg;
    always_comb begin
        p27_next = 1'b0;
        p26_next = 1'b0;
        p36_next = 1'b1;
        p37_next = 1'b1;
        case (op_next)
            EPV_OP_CODE: p27_next = 1'b1;
            EPV_OP_ENC: begin
                p27_next = 1'b1;
                p36_next = 1'b0;
            end
            EPV_OP_LOCK1: begin
                p27_next = 1'b1;
                p26_next = 1'b1;
            end
            EPV_OP_LOCK2: begin
                p27_next = 1'b1;
                p26_next = 1'b1;
                p36_next = 1'b0;
                p37_next = 1'b0;
            end
            EPV_OP_SIG: begin
                p36_next = 1'b0;
                p37_next = 1'b0;
                p27_next = !rd_next;
            end
            default: p27_next = !rd_next;
        endcase
        if (state_next == EPV_IDLE) begin
            p27_next = 1'b0;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            p27_reg <= 1'b0;
            p26_reg <= 1'b0;
            p36_reg <= 1'b1;
            p37_reg <= 1'b1;
            reset_reg <= 1'b0;
            osc_pin_reg <= 1'b0;
        end else begin
            p27_reg <= p27_next;
            p26_reg <= p26_next;
            p36_reg <= p36_next;
            p37_reg <= p37_next;
            reset_reg <= 1'b1;
            osc_pin_reg <= osc_w;
        end
    end

    assign cmd_ready = ready_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_data = rsp_data_reg;
    assign rsp_match = rsp_match_reg;
    assign target_osc = osc_pin_reg;
    assign target_reset = reset_reg;
    assign code_store_enable_pin = 1'b0 & reset_reg;
    assign program_strobe = strobe_reg;
    assign vpp_high_req = vpp_reg;
    // with vpp off the pin sits at valid high, matching latched level
    assign external_access_vpp_pin = reset_reg;
    assign port1_out = addr_reg[7:0];
    assign port2_addr_out = addr_reg[12:8];
    assign port2_bit7_enable = p27_reg;
    assign port2_bit6_select = p26_reg;
    assign port3_bit6_select = p36_reg;
    assign port3_bit7_select = p37_reg;
    assign port0_out = data_reg;
    assign port0_oe = oe_reg;
endmodule
`default_nettype wire

// file: tb/epv_programmer_sva.sv
// port checker for the eprom programmer controller
`timescale 1ns/1ps
`default_nettype none
module epv_programmer_sva #(
    parameter int PULSE_CYC = 20,
    parameter int PULSE_COUNT = 4,
    parameter int GAP_CYC = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic target_reset,
    input wire logic program_strobe,
    input wire logic vpp_high_req,
    input wire logic [7:0] port1_out,
    input wire logic [4:0] port2_addr_out,
    input wire logic port2_bit7_enable,
    input wire logic port2_bit6_select,
    input wire logic port3_bit6_select,
    input wire logic port3_bit7_select,
    input wire logic [7:0] port0_out,
    input wire logic port0_oe
);
    int lo_cnt;
    int hi_cnt;
    int pcnt;
    logic [21:0] pins;
    logic [2:0] mode;
    assign pins = {port1_out, port2_addr_out, port0_out, port0_oe};
    assign mode = {port2_bit6_select, port3_bit6_select, port3_bit7_select};
    // hi_cnt saturates so the idle time never wraps into a short gap
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lo_cnt <= 0;
            hi_cnt <= 1000;
            pcnt <= 0;
        end else begin
            lo_cnt <= program_strobe ? 0 : lo_cnt + 1;
            hi_cnt <= !program_strobe ? 0 :
                (hi_cnt < 1000 ? hi_cnt + 1 : 1000);
            if (cmd_ready)
                pcnt <= 0;
            else if (!program_strobe && lo_cnt == 0)
                pcnt <= pcnt + 1;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    AST_STROBE_VPP: assert property (
        !program_strobe |-> vpp_high_req && $past(vpp_high_req, 8))
        else $error("strobe low without vpp setup");
    AST_VPP_HOLD: assert property (
        $rose(program_strobe) |-> vpp_high_req [*8])
        else $error("vpp dropped too soon");
    AST_PULSE_WIDTH: assert property (
        $rose(program_strobe) |-> lo_cnt >= PULSE_CYC &&
            lo_cnt <= PULSE_CYC + 1)
        else $error("strobe pulse width wrong");
    AST_PULSE_GAP: assert property (
        $fell(program_strobe) |-> hi_cnt >= GAP_CYC)
        else $error("strobe gap too short");
    AST_PULSE_COUNT: assert property (
        rsp_valid |-> pcnt == 0 || pcnt == PULSE_COUNT)
        else $error("wrong number of strobe pulses");
    AST_MODE_PINS: assert property (
        !program_strobe |-> target_reset && port2_bit7_enable &&
            mode inside {3'h3, 3'h1, 3'h7, 3'h4})
        else $error("mode pins wrong during pulse");
    AST_ADDR_HOLD: assert property (
        $rose(program_strobe) |-> $stable(pins) [*8])
        else $error("address or data moved after pulse");
    AST_VERIFY_LEVELS: assert property (
        !port2_bit7_enable |-> program_strobe && !vpp_high_req && !port0_oe)
        else $error("verify levels wrong");
    cover property ($rose(program_strobe) && pcnt == PULSE_COUNT);
    cover property (!port2_bit7_enable && !port3_bit6_select && !cmd_ready);
    cover property (!program_strobe && port2_bit6_select);
endmodule
bind epv_programmer epv_programmer_sva #(
    .PULSE_CYC(PULSE_CYC), .PULSE_COUNT(PULSE_COUNT), .GAP_CYC(GAP_CYC)
) u_epv_programmer_sva (
    .sys_clk(sys_clk), .rst_n(rst_n), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .target_reset(target_reset),
    .program_strobe(program_strobe), .vpp_high_req(vpp_high_req),
    .port1_out(port1_out), .port2_addr_out(port2_addr_out),
    .port2_bit7_enable(port2_bit7_enable),
    .port2_bit6_select(port2_bit6_select),
    .port3_bit6_select(port3_bit6_select),
    .port3_bit7_select(port3_bit7_select),
    .port0_out(port0_out), .port0_oe(port0_oe)
);
`default_nettype wire

// file: tb/epv_dev_model.sv
// behavioural eprom device seen through its programming pins
`timescale 1ns/1ps
`default_nettype none
module epv_dev_model #(
    parameter logic [7:0] MFR_CODE = 8'h3a, // arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h6c, // arbitrary value
    parameter int RD_DLY = 60
) (
    input wire logic target_reset,
    input wire logic program_strobe,
    input wire logic vpp_high_req,
    input wire logic p27,
    input wire logic p26,
    input wire logic p36,
    input wire logic p37,
    input wire logic [12:0] addr,
    input wire logic [7:0] bus,
    output logic dev_oe,
    output logic [7:0] dev_data
);
    logic [7:0] mem [0:8191];
    logic [7:0] enc [0:31];
    logic lock_one;
    logic lock_two;
    logic rd_en;
    logic [7:0] rd_val;
    task automatic erase();
        for (int i = 0; i < 8192; i++)
            mem[i] = 8'hff;
        for (int i = 0; i < 32; i++)
            enc[i] = 8'hff;
        lock_one = 1'b0;
        lock_two = 1'b0;
    endtask
    initial erase();
    // unknown mode pins program nothing
    always @(negedge program_strobe) begin
        if (target_reset === 1'b1 && vpp_high_req === 1'b1 &&
            p27 === 1'b1) begin
            case ({p26, p36, p37})
                3'h3: if (!lock_one) mem[addr] &= bus;
                3'h1: if (!lock_one) enc[addr[4:0]] &= bus;
                3'h7: lock_one = 1'b1;
                3'h4: lock_two = 1'b1;
                default: ;
            endcase
        end
    end
    // lock bits have no read path at all
    always @* begin
        rd_en = target_reset === 1'b1 && program_strobe === 1'b1 &&
            vpp_high_req === 1'b0 && p27 === 1'b0 && p26 === 1'b0;
        if (lock_one && lock_two)
            rd_en = 1'b0;
        if (p36 === 1'b0 && p37 === 1'b0)
            rd_val = addr == 13'h0030 ? MFR_CODE :
                (addr == 13'h0031 ? DEV_CODE : 8'hff);
        else
            rd_val = ~(mem[addr] ^ enc[addr[4:0]]);
    end
    assign #(RD_DLY) dev_oe = rd_en;
    assign #(RD_DLY) dev_data = rd_val;
endmodule
`default_nettype wire

// file: tb/epv_programmer_tb.sv
// testbench for the eprom programmer controller
`timescale 1ns/1ps
`default_nettype none
module epv_programmer_tb;
    import epv_pkg::*;
    typedef struct {
        epv_op_t op;
        logic [12:0] a;
        logic [7:0] d;
        logic [7:0] er;
        logic em;
    } epv_row_t;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    epv_op_t cmd_op = EPV_OP_VERIFY;
    logic [12:0] cmd_addr = 13'h0000;
    logic [7:0] cmd_data = 8'h00;
    logic rdy, rsp_valid, rsp_match, trst, prog_n, vpp, p27, p26, p36, p37;
    logic oe, dev_oe, osc, store_en, ext_acc, osc_prev;
    logic [7:0] rst_pins;
    int rises = 0;
    logic [7:0] rsp_data, p1, p0o, p0, dev_d;
    logic [4:0] p2a;
    int n_mismatch = 0;
    int n_tests = 0;
    epv_row_t rows [14] = '{
        '{EPV_OP_CODE, 13'h0005, 8'ha5, 8'ha5, 1'b1},
        '{EPV_OP_CODE, 13'h1234, 8'h3c, 8'h3c, 1'b1},
        '{EPV_OP_VERIFY, 13'h0005, 8'ha5, 8'ha5, 1'b1},
        '{EPV_OP_VERIFY, 13'h1fff, 8'hff, 8'hff, 1'b1},
        '{EPV_OP_SIG, 13'h0030, 8'h3a, 8'h3a, 1'b1},
        '{EPV_OP_SIG, 13'h0031, 8'h6c, 8'h6c, 1'b1},
        '{EPV_OP_ENC, 13'h0005, 8'h0f, 8'h00, 1'b1},
        '{EPV_OP_VERIFY, 13'h0005, 8'h55, 8'h55, 1'b1},
        '{EPV_OP_VERIFY, 13'h0025, 8'h0f, 8'h0f, 1'b1},
        '{EPV_OP_LOCK1, 13'h0000, 8'h00, 8'h00, 1'b1},
        '{EPV_OP_CODE, 13'h0006, 8'h00, 8'hff, 1'b0},
        '{EPV_OP_VERIFY, 13'h0005, 8'h55, 8'h55, 1'b1},
        '{EPV_OP_LOCK2, 13'h0000, 8'h00, 8'h00, 1'b1},
        '{EPV_OP_VERIFY, 13'h0005, 8'h55, 8'hff, 1'b0}};
    always #20 sys_clk = ~sys_clk;
    assign p0 = oe ? p0o : (dev_oe ? dev_d : 8'hff);
    assign rst_pins = {1'b0, prog_n, vpp, rdy, oe, trst, p36, p37};
    epv_programmer #(
        .PULSE_CYC(20), .PULSE_COUNT(4), .GAP_CYC(4), .SETTLE_CYC(3)
    ) u_epv_programmer (
        .sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_ready(rdy), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_match(rsp_match), .target_osc(osc), .target_reset(trst),
        .code_store_enable_pin(store_en), .program_strobe(prog_n),
        .vpp_high_req(vpp), .external_access_vpp_pin(ext_acc),
        .port1_out(p1), .port2_addr_out(p2a), .port2_bit7_enable(p27),
        .port2_bit6_select(p26), .port3_bit6_select(p36),
        .port3_bit7_select(p37), .port0_out(p0o), .port0_oe(oe),
        .port0_in(p0)
    );
    epv_dev_model u_epv_dev_model (
        .target_reset(trst), .program_strobe(prog_n), .vpp_high_req(vpp),
        .p27(p27), .p26(p26), .p36(p36), .p37(p37), .addr({p2a, p1}),
        .bus(p0), .dev_oe(dev_oe), .dev_data(dev_d)
    );
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one operation; the design is idle whenever this is entered
    task automatic do_op(input epv_row_t r);
        int i;
        i = 0;
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_op = r.op;
        cmd_addr = r.a;
        cmd_data = r.d;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && i < 4000) begin
            @(negedge sys_clk);
            i++;
        end
        if (i == 4000) begin
            n_mismatch++;
            summarize();
        end
    endtask
    initial begin
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            do_op(rows[i]);
            if (rows[i].op inside {EPV_OP_CODE, EPV_OP_VERIFY, EPV_OP_SIG})
                chk("rsp_data", rows[i].er, rsp_data);
            chk("match", {7'h00, rows[i].em}, {7'h00, rsp_match});
            $display("row %0d done", i);
        end
        // held request while busy, then reset long before any pulse
        cmd_op = EPV_OP_CODE;
        cmd_valid = 1'b1;
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        #1;
        chk("reset pins", 8'h53, rst_pins);
        u_epv_dev_model.erase();
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        do_op('{EPV_OP_LOCK2, 13'h0000, 8'h00, 8'h00, 1'b1});
        do_op('{EPV_OP_CODE, 13'h0040, 8'h96, 8'h96, 1'b1});
        chk("reserved lock", 8'h96, rsp_data);
        $display("reset and reserved lock test done");
        // 20 cycles of 40 ns hold 3 to 5 periods at 4 to 6 mhz
        osc_prev = osc;
        repeat (20) begin
            @(negedge sys_clk);
            if (osc === 1'b1 && osc_prev === 1'b0)
                rises++;
            osc_prev = osc;
        end
        chk("osc rate", 8'h01, {7'h00, rises inside {[3:5]}});
        chk("idle pins", 8'h01, {6'h00, store_en, ext_acc});
        $display("clock and fixed pin test done");
        summarize();
    end
endmodule
`default_nettype wire
